// ### rtl/idt_pkg.sv
package idt_pkg;

    // instruction widths
    localparam int unsigned IDT_OPC_W  = 8;     // opcode width
    localparam int unsigned IDT_LEN_W  = 2;     // byte count width
    localparam int unsigned IDT_CYC_W  = 4;     // cycle count width
    localparam int unsigned IDT_CLS_W  = 5;     // class code width

    // byte counts
    localparam logic [1:0] IDT_LEN_1 = 2'h1;    // one-byte instruction
    localparam logic [1:0] IDT_LEN_2 = 2'h2;    // two-byte instruction
    localparam logic [1:0] IDT_LEN_3 = 2'h3;    // three-byte instruction

    // cycle counts
    localparam logic [3:0] IDT_CYC_1 = 4'h1;    // single cycle
    localparam logic [3:0] IDT_CYC_2 = 4'h2;    // two cycles
    localparam logic [3:0] IDT_CYC_3 = 4'h3;    // three cycles
    localparam logic [3:0] IDT_CYC_4 = 4'h4;    // multiply
    localparam logic [3:0] IDT_CYC_8 = 4'h8;    // divide
    localparam logic [3:0] IDT_CYC_0 = 4'h0;    // none
    localparam logic [3:0] IDT_TAKEN_EXTRA = 4'h1; // taken branch adds one cycle

    // operand field positions
    localparam int unsigned IDT_RN_LSB = 0;     // register select low bit
    localparam int unsigned IDT_RI_BIT = 0;     // indirect pointer select bit
    localparam logic [2:0] IDT_RN_MAX = 3'h7;   // highest working register

    // operation classes
    typedef enum logic [4:0] {
        IDT_CLS_NOP   = 5'h00,
        IDT_CLS_ADD   = 5'h01,
        IDT_CLS_ADDC  = 5'h02,
        IDT_CLS_SUBB  = 5'h03,
        IDT_CLS_INC   = 5'h04,
        IDT_CLS_DEC   = 5'h05,
        IDT_CLS_INCDP = 5'h06,
        IDT_CLS_MUL   = 5'h07,
        IDT_CLS_DIV   = 5'h08,
        IDT_CLS_DA    = 5'h09,
        IDT_CLS_ANL   = 5'h0a,
        IDT_CLS_ORL   = 5'h0b,
        IDT_CLS_XRL   = 5'h0c,
        IDT_CLS_CLR   = 5'h0d,
        IDT_CLS_CPL   = 5'h0e,
        IDT_CLS_RL    = 5'h0f,
        IDT_CLS_RLC   = 5'h10,
        IDT_CLS_RR    = 5'h11,
        IDT_CLS_RRC   = 5'h12,
        IDT_CLS_SWAP  = 5'h13,
        IDT_CLS_MOV   = 5'h14,
        IDT_CLS_BRANCH= 5'h15,
        IDT_CLS_OTHER = 5'h16
    } idt_cls_t;

    // operand addressing modes
    typedef enum logic [2:0] {
        IDT_AM_NONE = 3'h0,
        IDT_AM_ACC  = 3'h1,
        IDT_AM_REG  = 3'h2,
        IDT_AM_IND  = 3'h3,
        IDT_AM_DIR  = 3'h4,
        IDT_AM_IMM  = 3'h5,
        IDT_AM_DATA_POINTER_16BIT = 3'h6
    } idt_am_t;

    // decode result bundle
    typedef struct packed {
        idt_cls_t    cls;        // operation class
        idt_am_t     dst;        // destination mode
        idt_am_t     src;        // source mode
        logic [1:0]  len;        // byte count
        logic [3:0]  cyc_off;    // cycles, prefetch off
        logic [3:0]  cyc_on;     // cycles, prefetch on
        logic        cond;       // conditional branch
        logic        known;      // opcode covered here
    } idt_dec_t;

endpackage

// ### rtl/idt_dec_if.sv
`timescale 1ns/10ps
// carries one decoded instruction from decoder to sequencer
interface idt_dec_if;
    import idt_pkg::*;
    idt_dec_t   dec;        // decoded fields
    logic [7:0] opc;        // raw opcode
    modport dcd (output dec, input opc);
    modport seq (input dec, output opc);
endinterface

// ### rtl/idt_decoder.sv
`timescale 1ns/10ps
// combinational opcode to length/timing/class table
module idt_decoder (
    idt_dec_if.dcd d    // decode bundle
);
    import idt_pkg::*;

    // fill one entry; both prefetch counts equal for these groups
    function automatic idt_dec_t mk(input idt_cls_t c, input idt_am_t ds, input idt_am_t sr,
                                    input logic [1:0] l, input logic [3:0] cy);
        idt_dec_t r;
        r = '0;
        r.cls = c;
        r.dst = ds;
        r.src = sr;
        r.len = l;
        r.cyc_off = cy;
        r.cyc_on = cy;
        r.known = 1'b1;
        return r;
    endfunction

    // low-nibble operand mode of the regular column layout
    function automatic idt_am_t col_mode(input logic [7:0] o);
        if (o[3]) return IDT_AM_REG;
        if (o[3:1] == 3'h3) return IDT_AM_IND;
        if (o[3:0] == 4'h5) return IDT_AM_DIR;
        if (o[3:0] == 4'h4) return IDT_AM_IMM;
        return IDT_AM_NONE;
    endfunction

    idt_am_t   m;       // column mode of current opcode
    logic [1:0] ln;     // column byte count
    logic [3:0] cy;     // column cycle count
    idt_cls_t   lc;     // logical op class of rows 4 to 6

    // decode table
    always_comb begin
        m  = col_mode(d.opc);
        ln = (m == IDT_AM_DIR || m == IDT_AM_IMM) ? IDT_LEN_2 : IDT_LEN_1;
        cy = (m == IDT_AM_REG) ? IDT_CYC_1 : IDT_CYC_2;
        lc = (d.opc[5:4] == 2'h0) ? IDT_CLS_ORL :
             (d.opc[5:4] == 2'h1) ? IDT_CLS_ANL : IDT_CLS_XRL;
        d.dec = '0;
        d.dec.cls = IDT_CLS_OTHER;
        unique case (d.opc[7:4])
            4'h0, 4'h1: begin
                // inc (0x) / dec (1x) columns
                if (d.opc[3:0] == 4'h4) d.dec = mk(d.opc[4] ? IDT_CLS_DEC : IDT_CLS_INC,
                    IDT_AM_ACC, IDT_AM_NONE, IDT_LEN_1, IDT_CYC_1);
                else if (m == IDT_AM_REG || m == IDT_AM_IND)
                    d.dec = mk(d.opc[4] ? IDT_CLS_DEC : IDT_CLS_INC, m, IDT_AM_NONE,
                        IDT_LEN_1, cy);
                else if (m == IDT_AM_DIR)
                    d.dec = mk(d.opc[4] ? IDT_CLS_DEC : IDT_CLS_INC, m, IDT_AM_NONE, IDT_LEN_2,
                        IDT_CYC_2);
                else if (d.opc[3:0] == 4'h3) d.dec = mk(d.opc[4] ? IDT_CLS_RRC : IDT_CLS_RR,
                    IDT_AM_ACC, IDT_AM_NONE, IDT_LEN_1, IDT_CYC_1);
                if (d.opc == 8'h00) d.dec = mk(IDT_CLS_NOP, IDT_AM_NONE, IDT_AM_NONE,
                    IDT_LEN_1, IDT_CYC_1);
            end
            4'h2, 4'h3, 4'h9: begin
                // add / addc / subb into accumulator
                if (m != IDT_AM_NONE) d.dec = mk(d.opc[7] ? IDT_CLS_SUBB :
                    (d.opc[4] ? IDT_CLS_ADDC : IDT_CLS_ADD), IDT_AM_ACC, m, ln, cy);
                else if (d.opc[7:0] == 8'h23 || d.opc[7:0] == 8'h33)
                    d.dec = mk(d.opc[4] ? IDT_CLS_RLC : IDT_CLS_RL, IDT_AM_ACC, IDT_AM_NONE,
                        IDT_LEN_1, IDT_CYC_1);
            end
            4'h4, 4'h5, 4'h6: begin
                // logical ops: accumulator or direct destination
                if (m != IDT_AM_NONE) d.dec = mk(lc, IDT_AM_ACC, m, ln, cy);
                else if (d.opc[3:0] == 4'h2) d.dec = mk(lc, IDT_AM_DIR, IDT_AM_ACC,
                    IDT_LEN_2, IDT_CYC_2);
                else if (d.opc[3:0] == 4'h3) d.dec = mk(lc, IDT_AM_DIR, IDT_AM_IMM,
                    IDT_LEN_3, IDT_CYC_3);
            end
            4'h7: begin
                // move immediate to acc / indirect / register / direct
                if (d.opc[3:0] == 4'h4) d.dec = mk(IDT_CLS_MOV, IDT_AM_ACC, IDT_AM_IMM,
                    IDT_LEN_2, IDT_CYC_2);
                else if (m == IDT_AM_REG || m == IDT_AM_IND)
                    d.dec = mk(IDT_CLS_MOV, m, IDT_AM_IMM, IDT_LEN_2, IDT_CYC_2);
                else if (d.opc[3:0] == 4'h5) d.dec = mk(IDT_CLS_MOV, IDT_AM_DIR,
                    IDT_AM_IMM, IDT_LEN_3, IDT_CYC_3);
            end
            4'h8: begin
                // mov direct,direct / mov direct,@Ri / mov direct,Rn
                if (d.opc[3:0] == 4'h5) d.dec = mk(IDT_CLS_MOV, IDT_AM_DIR, IDT_AM_DIR,
                    IDT_LEN_3, IDT_CYC_3);
                else if (m == IDT_AM_REG || m == IDT_AM_IND)
                    d.dec = mk(IDT_CLS_MOV, IDT_AM_DIR, m, IDT_LEN_2, IDT_CYC_2);
                else if (d.opc[3:0] == 4'h4) d.dec = mk(IDT_CLS_DIV, IDT_AM_ACC,
                    IDT_AM_NONE, IDT_LEN_1, IDT_CYC_8);
            end
            4'ha: begin
                // mov Rn/@Ri,direct, inc data_pointer_16bit, mul, spare nop
                if (m == IDT_AM_REG || m == IDT_AM_IND)
                    d.dec = mk(IDT_CLS_MOV, m, IDT_AM_DIR, IDT_LEN_2, IDT_CYC_2);
                else if (d.opc[3:0] == 4'h3) d.dec = mk(IDT_CLS_INCDP, IDT_AM_DATA_POINTER_16BIT,
                    IDT_AM_NONE, IDT_LEN_1, IDT_CYC_1);
                else if (d.opc[3:0] == 4'h4) d.dec = mk(IDT_CLS_MUL, IDT_AM_ACC,
                    IDT_AM_NONE, IDT_LEN_1, IDT_CYC_4);
                else if (d.opc[3:0] == 4'h5) d.dec = mk(IDT_CLS_NOP, IDT_AM_NONE,
                    IDT_AM_NONE, IDT_LEN_1, IDT_CYC_1);
            end
            4'hc, 4'hd, 4'he, 4'hf: begin
                // swap/da/clr/cpl and mov with accumulator
                if (d.opc == 8'hc4) d.dec = mk(IDT_CLS_SWAP, IDT_AM_ACC, IDT_AM_NONE,
                    IDT_LEN_1, IDT_CYC_1);
                else if (d.opc == 8'hd4) d.dec = mk(IDT_CLS_DA, IDT_AM_ACC, IDT_AM_NONE,
                    IDT_LEN_1, IDT_CYC_1);
                else if (d.opc == 8'he4) d.dec = mk(IDT_CLS_CLR, IDT_AM_ACC, IDT_AM_NONE,
                    IDT_LEN_1, IDT_CYC_1);
                else if (d.opc == 8'hf4) d.dec = mk(IDT_CLS_CPL, IDT_AM_ACC, IDT_AM_NONE,
                    IDT_LEN_1, IDT_CYC_1);
                else if (d.opc[7:4] == 4'he && m != IDT_AM_NONE && m != IDT_AM_IMM)
                    d.dec = mk(IDT_CLS_MOV, IDT_AM_ACC, m, ln, cy);
                else if (d.opc[7:4] == 4'hf && (m == IDT_AM_REG || m == IDT_AM_IND))
                    d.dec = mk(IDT_CLS_MOV, m, IDT_AM_ACC, IDT_LEN_1, cy);
                else if (d.opc == 8'hf5) d.dec = mk(IDT_CLS_MOV, IDT_AM_DIR, IDT_AM_ACC,
                    IDT_LEN_2, IDT_CYC_2);
                else if (d.opc[7:4] == 4'hd && d.opc[3])
                    d.dec = mk(IDT_CLS_BRANCH, IDT_AM_REG, IDT_AM_NONE, IDT_LEN_2, IDT_CYC_2);
            end
            4'hb: begin
                // compare-and-jump family, treated as conditional branches
                if (d.opc[3] || d.opc[3:2] == 2'h1) d.dec = mk(IDT_CLS_BRANCH, m,
                    IDT_AM_IMM, IDT_LEN_3, IDT_CYC_3);
            end
        endcase
        if (d.dec.cls == IDT_CLS_BRANCH) d.dec.cond = 1'b1;
    end

endmodule // idt_decoder

// ### rtl/idt_core_timing.sv
`timescale 1ns/10ps
// What this block does
// - opcodes match the classic 8-bit set
// - timing counts core clocks, no machine cycles
// - most instructions take one cycle per byte
// - untaken conditional branch one cycle shorter
// - add/addc/subb register: one byte, one cycle
// - add/addc/subb indirect: one byte, two cycles
// - add/addc/subb direct/immediate: two bytes, two cycles
// - inc/dec reg one cycle, memory two
// - logic into acc: register one, others two
// - logic to direct: acc 2/2, immediate 3/3
// - acc clear/complement/rotate/swap: one byte, one cycle
// - acc-register move one cycle, three-byte moves three, others two
// - direct-to-direct move: three bytes, three cycles
// - fixed length, equal prefetch on/off counts
// - eight bank registers; indirect via r0/r1
module idt_core_timing (
    input  wire logic                       core_clk_i,     // core clock, 125 MHz
    input  wire logic                       rst_n_i,        // async reset, active low
    input  wire logic                       prefetch_en_i,  // prefetch engine enabled
    input  wire logic [1:0]                 bank_sel_i,     // selected register bank
    input  wire logic                       opc_valid_i,    // opcode byte offered
    input  wire logic [7:0]                 opc_i,          // opcode byte
    input  wire logic                       br_taken_i,     // branch condition result
    output logic                            opc_ready_o,    // opcode taken this cycle
    output logic                            busy_o,         // instruction executing
    output logic                            retire_o,       // last cycle pulse
    output idt_pkg::idt_cls_t               cls_o,          // operation class
    output logic [1:0]                      len_o,          // byte length
    output logic [3:0]                      cyc_o,          // cycles charged
    output logic                            known_o,        // opcode covered
    output logic [4:0]                      reg_addr_o,     // working register ram address
    output logic                            ptr_sel_o       // indirect uses r1
);
    import idt_pkg::*;

    // timing state machine
    typedef enum logic [1:0] {
        IDT_ST_IDLE = 2'b00,
        IDT_ST_EXEC = 2'b01
    } idt_st_t;

    idt_dec_if  dif ();         // decoder bundle
    idt_st_t    st_q;           // sequencer state
    logic [3:0] cnt_q;          // cycles remaining
    logic [3:0] cyc_d;          // cycle total for new instruction
    logic       take;           // opcode accepted

    // operand register address: bank times eight plus register number
    function automatic logic [4:0] reg_addr(input logic [1:0] b, input logic [2:0] r);
        return {b, r};
    endfunction

    assign dif.opc = opc_i;

    // length and timing table
    idt_decoder u_dec (
        .d (dif.dcd)
    );

    assign take = opc_valid_i && (st_q == IDT_ST_IDLE || cnt_q == IDT_CYC_1);

    // cycle count chosen by prefetch mode and branch outcome
    always_comb begin
        cyc_d = prefetch_en_i ? dif.dec.cyc_on : dif.dec.cyc_off;
        if (dif.dec.cond && br_taken_i) begin
            cyc_d = cyc_d + IDT_TAKEN_EXTRA;
        end
        if (!dif.dec.known) begin
            cyc_d = IDT_CYC_1;              // unknown rows take one cycle here
        end
    end

    // sequencer: one count step per core clock
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q  <= IDT_ST_IDLE;
            cnt_q <= IDT_CYC_0;
        end else if (take) begin
            st_q  <= IDT_ST_EXEC;
            cnt_q <= cyc_d;
        end else if (st_q == IDT_ST_EXEC) begin
            if (cnt_q == IDT_CYC_1) begin
                st_q  <= IDT_ST_IDLE;
                cnt_q <= IDT_CYC_0;
            end else begin
                cnt_q <= cnt_q - IDT_CYC_1;
            end
        end
    end

    // decoded attributes latched with the opcode
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cls_o      <= IDT_CLS_NOP;
            len_o      <= IDT_LEN_1;
            cyc_o      <= IDT_CYC_0;
            known_o    <= 1'b0;
            reg_addr_o <= 5'h00;
            ptr_sel_o  <= 1'b0;
        end else if (take) begin
            cls_o      <= dif.dec.cls;
            len_o      <= dif.dec.len;
            cyc_o      <= cyc_d;
            known_o    <= dif.dec.known;
            reg_addr_o <= reg_addr(bank_sel_i, opc_i[2:0]);
            ptr_sel_o  <= opc_i[IDT_RI_BIT];
        end
    end

    // handshake and status outputs
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opc_ready_o <= 1'b0;
            busy_o      <= 1'b0;
            retire_o    <= 1'b0;
        end else begin
            opc_ready_o <= take;
            busy_o      <= take || (st_q == IDT_ST_EXEC && cnt_q != IDT_CYC_1);
            retire_o    <= (st_q == IDT_ST_EXEC && cnt_q == IDT_CYC_1);
        end
    end

endmodule // idt_core_timing

// ### verification/idt_core_timing_assertions.sv
`timescale 1ns/10ps
// watches the timing core ports: take, refusal, hold and retire timing
module idt_core_timing_assertions
    import idt_pkg::*;
(
    input wire logic          core_clk_i,    // core clock
    input wire logic          rst_n_i,       // async reset, active low
    input wire logic          prefetch_en_i, // prefetch mode
    input wire logic [1:0]    bank_sel_i,    // register bank
    input wire logic          opc_valid_i,   // opcode offered
    input wire logic [7:0]    opc_i,         // opcode byte
    input wire logic          br_taken_i,    // branch condition
    input wire logic          opc_ready_o,   // opcode taken
    input wire logic          busy_o,        // executing
    input wire logic          retire_o,      // last cycle done
    input idt_pkg::idt_cls_t  cls_o,         // operation class
    input wire logic [1:0]    len_o,         // byte length
    input wire logic [3:0]    cyc_o,         // cycles charged
    input wire logic          known_o,       // opcode covered
    input wire logic [4:0]    reg_addr_o,    // register address
    input wire logic          ptr_sel_o      // indirect pointer select
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // an idle core takes an offered opcode at once
    a_idle_take: assert property (opc_valid_i && !busy_o |=> opc_ready_o && busy_o)
        else $error("idle core did not take offered opcode");
    // a multi-cycle instruction refuses the next opcode in its first cycle
    a_refuse_busy: assert property (opc_ready_o && cyc_o > 4'h1 |=> !opc_ready_o)
        else $error("opcode taken while core busy");
    a_one_cycle: assert property (opc_ready_o && cyc_o == 4'h1 |=> retire_o)
        else $error("single cycle instruction late");
    a_two_cycle: assert property (
        opc_ready_o && cyc_o == 4'h2 |=> !retire_o ##1 retire_o)
        else $error("two cycle instruction wrong length");
    a_three_byte: assert property (opc_ready_o && len_o == 2'h3
        && cls_o != IDT_CLS_BRANCH |-> cyc_o == 4'h3 ##3 retire_o)
        else $error("three byte instruction not three cycles");
    a_div_time: assert property (opc_ready_o && cls_o == IDT_CLS_DIV
        |-> cyc_o == 4'h8 ##8 retire_o)
        else $error("divide not eight cycles");
    a_mul_time: assert property (opc_ready_o && cls_o == IDT_CLS_MUL
        |-> cyc_o == 4'h4 ##4 retire_o)
        else $error("multiply not four cycles");
    a_alu_two_byte: assert property (opc_ready_o && known_o && len_o == 2'h2
        && cls_o inside {IDT_CLS_ADD, IDT_CLS_ADDC, IDT_CLS_SUBB, IDT_CLS_ANL} |-> cyc_o == 4'h2)
        else $error("two byte arithmetic not two cycles");
    // register decrement branch: taken costs one more than not taken
    a_branch_extra: assert property (opc_valid_i && !busy_o && opc_i[7:3] == 5'h1b
        |=> cyc_o == ($past(br_taken_i) ? 4'h3 : 4'h2))
        else $error("branch cycle count ignores condition");
    a_reg_select: assert property (opc_valid_i && !busy_o |=> reg_addr_o ==
        {$past(bank_sel_i), $past(opc_i[2:0])} && ptr_sel_o == $past(opc_i[0]))
        else $error("register or pointer select wrong");
    a_attr_hold: assert property (!opc_ready_o |-> $stable(len_o) && $stable(cyc_o))
        else $error("attributes changed without a take");
    a_retire_idle: assert property (retire_o && !opc_ready_o |-> !busy_o)
        else $error("busy after retire");
endmodule // idt_core_timing_assertions

bind idt_core_timing idt_core_timing_assertions i_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .prefetch_en_i(prefetch_en_i),
    .bank_sel_i(bank_sel_i), .opc_valid_i(opc_valid_i), .opc_i(opc_i),
    .br_taken_i(br_taken_i), .opc_ready_o(opc_ready_o), .busy_o(busy_o),
    .retire_o(retire_o), .cls_o(cls_o), .len_o(len_o), .cyc_o(cyc_o),
    .known_o(known_o), .reg_addr_o(reg_addr_o), .ptr_sel_o(ptr_sel_o)
);

// ### verification/idt_core_timing_test.sv
`timescale 1ns/10ps
// drives opcodes back to back and compares with a table model
module idt_core_timing_test;
    import idt_pkg::*;
    logic        core_clk_i = 1'b0;    // core clock
    logic        rst_n_i = 1'b0;       // reset, active low
    logic        prefetch_en_i = 1'b0; // prefetch mode
    logic [1:0]  bank_sel_i = 2'h0;    // register bank
    logic        opc_valid_i = 1'b0;   // opcode offered
    logic [7:0]  opc_i = 8'h00;        // opcode byte
    logic        br_taken_i = 1'b0;    // branch condition
    logic        opc_ready_o, busy_o, retire_o, known_o, ptr_sel_o;
    idt_cls_t    cls_o;                // class seen
    logic [1:0]  len_o;                // length seen
    logic [3:0]  cyc_o;                // cycles seen
    logic [4:0]  reg_addr_o;           // register address seen
    logic [31:0] lfsr_q = 32'hd291_e185; // random source
    logic [17:0] exp_q[$];             // expected attributes per take
    int          ret_q[$];             // expected retire edge numbers
    logic [17:0] e;                    // record being compared
    logic [11:0] m;                    // model lookup
    logic [7:0]  br_list [3] = '{8'hdb, 8'hb4, 8'hbe}; // branch opcodes
    int          edge_n = 0;           // edge counter
    int          num_errors = 0;       // mismatches
    int          check_count = 0;      // comparisons
    int          k;                    // loop index

    always #4 core_clk_i = ~core_clk_i; // 125 MHz

    idt_core_timing i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .prefetch_en_i(prefetch_en_i), .bank_sel_i(bank_sel_i), .opc_valid_i(opc_valid_i),
        .opc_i(opc_i), .br_taken_i(br_taken_i), .opc_ready_o(opc_ready_o), .busy_o(busy_o),
        .retire_o(retire_o), .cls_o(cls_o), .len_o(len_o), .cyc_o(cyc_o), .known_o(known_o),
        .reg_addr_o(reg_addr_o), .ptr_sel_o(ptr_sel_o));

    function automatic logic [31:0] lfsr_nx(input logic [31:0] s);
        lfsr_nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // table model: {known, class, length, cycles}
    function automatic logic [11:0] mdl(input logic [7:0] o);
        idt_cls_t    c;
        logic [11:0] r;
        c = IDT_CLS_NOP;
        r = 12'h000;
        case (o[7:4]) // rows sharing the accumulator operand layout
            4'h0: c = IDT_CLS_INC;
            4'h1: c = IDT_CLS_DEC;
            4'h2: c = IDT_CLS_ADD;
            4'h3: c = IDT_CLS_ADDC;
            4'h4: c = IDT_CLS_ORL;
            4'h5: c = IDT_CLS_ANL;
            4'h6: c = IDT_CLS_XRL;
            4'h9: c = IDT_CLS_SUBB;
            default: c = IDT_CLS_NOP;
        endcase
        if (c != IDT_CLS_NOP && o[3:0] >= 4'h4) begin
            if (o[3]) r = {1'b1, c, 2'h1, 4'h1};
            else if (o[2:1] == 2'b11) r = {1'b1, c, 2'h1, 4'h2};
            else if (o[7:5] == 3'h0 && !o[0]) r = {1'b1, c, 2'h1, 4'h1};
            else r = {1'b1, c, 2'h2, 4'h2};
        end
        if (c inside {IDT_CLS_ORL, IDT_CLS_ANL, IDT_CLS_XRL} && o[3:1] == 3'h1) begin
            r = {1'b1, c, 1'b1, o[0], 3'h1, o[0]};
        end
        case (o)
            8'ha3: r = {1'b1, IDT_CLS_INCDP, 2'h1, 4'h1};
            8'ha4: r = {1'b1, IDT_CLS_MUL, 2'h1, 4'h4};
            8'h84: r = {1'b1, IDT_CLS_DIV, 2'h1, 4'h8};
            8'hd4: r = {1'b1, IDT_CLS_DA, 2'h1, 4'h1};
            8'he4: r = {1'b1, IDT_CLS_CLR, 2'h1, 4'h1};
            8'hf4: r = {1'b1, IDT_CLS_CPL, 2'h1, 4'h1};
            8'h23: r = {1'b1, IDT_CLS_RL, 2'h1, 4'h1};
            8'h33: r = {1'b1, IDT_CLS_RLC, 2'h1, 4'h1};
            8'h03: r = {1'b1, IDT_CLS_RR, 2'h1, 4'h1};
            8'h13: r = {1'b1, IDT_CLS_RRC, 2'h1, 4'h1};
            8'hc4: r = {1'b1, IDT_CLS_SWAP, 2'h1, 4'h1};
            8'h74, 8'he5, 8'hf5, 8'h86, 8'h87: r = {1'b1, IDT_CLS_MOV, 2'h2, 4'h2};
            8'he6, 8'he7: r = {1'b1, IDT_CLS_MOV, 2'h1, 4'h2};
            8'h85, 8'h75: r = {1'b1, IDT_CLS_MOV, 2'h3, 4'h3};
            8'h76, 8'h77, 8'ha6, 8'ha7: r = {1'b1, IDT_CLS_MOV, 2'h2, 4'h2};
            8'hf6, 8'hf7: r = {1'b1, IDT_CLS_MOV, 2'h1, 4'h2};
            8'h00, 8'ha5: r = {1'b1, IDT_CLS_NOP, 2'h1, 4'h1};
            8'hb4: r = {1'b0, IDT_CLS_BRANCH, 2'h3, 4'h3};
            default: r = r;
        endcase
        case (o[7:3])
            5'h1d, 5'h1f: r = {1'b1, IDT_CLS_MOV, 2'h1, 4'h1};
            5'h15, 5'h0f, 5'h11: r = {1'b1, IDT_CLS_MOV, 2'h2, 4'h2};
            5'h1b: r = {1'b0, IDT_CLS_BRANCH, 2'h2, 4'h2};
            5'h17: r = {1'b0, IDT_CLS_BRANCH, 2'h3, 4'h3};
            default: r = r;
        endcase
        mdl = r;
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // offer one opcode; busy cycles carry random refused opcodes
    task automatic send(input logic [7:0] o, input logic tk, input logic chain);
        logic [11:0] r;
        logic [3:0]  n;
        r = mdl(o);
        n = r[3:0] + ((r[10:6] == IDT_CLS_BRANCH && tk) ? 4'h1 : 4'h0);
        lfsr_q = lfsr_nx(lfsr_q);
        opc_valid_i <= 1'b1;
        opc_i <= o;
        br_taken_i <= tk;
        bank_sel_i <= lfsr_q[1:0];
        prefetch_en_i <= lfsr_q[2];
        exp_q.push_back({r[11], r[10:4], n, lfsr_q[1:0], o[2:0], o[0]});
        @(posedge core_clk_i);
        for (int i = 1; i < n; i++) begin
            lfsr_q = lfsr_nx(lfsr_q);
            opc_i <= lfsr_q[7:0];
            @(posedge core_clk_i);
        end
        if (!chain) begin
            opc_valid_i <= 1'b0;
            @(posedge core_clk_i);
        end
    endtask

    task automatic chk_reset();
        #1;
        chk("busy_rst", 16'(busy_o), 16'h0);
        chk("len_rst", 16'(len_o), 16'h1);
        chk("cls_rst", 16'(cls_o), 16'(IDT_CLS_NOP));
        chk("cyc_rst", 16'(cyc_o), 16'h0);
    endtask

    // scoreboard: compare attributes on each take and each retire edge
    always @(posedge core_clk_i) begin
        edge_n++;
        if (!rst_n_i) begin
            exp_q.delete();
            ret_q.delete();
        end else begin
            if (retire_o === 1'b1) begin
                if (ret_q.size() == 0) chk("retire_extra", 16'h1, 16'h0);
                else chk("retire_edge", 16'(edge_n), 16'(ret_q.pop_front()));
            end
            if (opc_ready_o === 1'b1) begin
                if (exp_q.size() == 0) chk("ready_extra", 16'h1, 16'h0);
                else begin
                    e = exp_q.pop_front();
                    chk("cls", 16'(cls_o), 16'(e[16:12]));
                    chk("len", 16'(len_o), 16'(e[11:10]));
                    chk("cyc", 16'(cyc_o), 16'(e[9:6]));
                    chk("reg_addr", 16'(reg_addr_o), 16'(e[5:1]));
                    chk("ptr_sel", 16'(ptr_sel_o), 16'(e[0]));
                    if (e[17]) chk("known", 16'(known_o), 16'h1);
                    ret_q.push_back(edge_n + int'(e[9:6]));
                end
            end
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        summarize();
    end

    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        chk_reset();
        @(posedge core_clk_i);
        for (k = 0; k < 256; k++) begin
            m = mdl(8'(k));
            if (m[11]) send(8'(k), lfsr_q[6], lfsr_q[5] && k != 255);
        end
        for (k = 0; k < 6; k++) send(br_list[k / 2], k[0], k[0] && k != 5);
        // reset in the middle of a divide: no retire may follow
        opc_valid_i <= 1'b1;
        opc_i <= 8'h84;
        exp_q.push_back({1'b1, IDT_CLS_DIV, 2'h1, 4'h8, bank_sel_i, 3'h4, 1'b0});
        @(posedge core_clk_i);
        opc_valid_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        chk_reset();
        repeat (12) @(posedge core_clk_i);
        chk("pending", 16'(exp_q.size() + ret_q.size()), 16'h0);
        summarize();
    end
endmodule // idt_core_timing_test
